/* File: hdl/atie_top.sv */
// Transmit interrupt enable block with APB register access
`timescale 1ns/10ps
`default_nettype none
`include "atie_consts.svh"

module atie_top (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`ATIE_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Transmitter condition events, one-cycle pulses
  input  wire logic                      frame_start_seen,
  input  wire logic                      tx_buffer_empty,
  input  wire logic                      final_slot_seen,
  input  wire logic                      excess_write_error,
  input  wire logic                      bit_clock_failure,
  input  wire logic                      unexpected_frame_sync,
  input  wire logic                      tx_underrun,
  // Interrupt to the processor
  output logic                           transmit_irq
);

  // ------------------------------------------------------------------
  // Layout helpers
  // ------------------------------------------------------------------

  // Condition vector to enable register layout; bit 6 stays zero
  function automatic logic [7:0] pack_enable(input atie_pkg::atie_cond_t c);
    logic [7:0] w;
    w                      = 8'h00;
    w[`ATIE_EN_STAFRM]     = c[`ATIE_C_STAFRM];
    w[`ATIE_EN_DATA]       = c[`ATIE_C_DATA];
    w[`ATIE_EN_LAST]       = c[`ATIE_C_LAST];
    w[`ATIE_EN_DMAERR]     = c[`ATIE_C_DMAERR];
    w[`ATIE_EN_CKFAIL]     = c[`ATIE_C_CKFAIL];
    w[`ATIE_EN_SYNCERR]    = c[`ATIE_C_SYNCERR];
    w[`ATIE_EN_UNDRN]      = c[`ATIE_C_UNDRN];
    return w;
  endfunction

  // Enable register layout to condition vector; reserved bits dropped
  function automatic atie_pkg::atie_cond_t unpack_enable(input logic [7:0] w);
    atie_pkg::atie_cond_t c;
    c                      = `ATIE_FLAGS_RESET;
    c[`ATIE_C_STAFRM]      = w[`ATIE_EN_STAFRM];
    c[`ATIE_C_DATA]        = w[`ATIE_EN_DATA];
    c[`ATIE_C_LAST]        = w[`ATIE_EN_LAST];
    c[`ATIE_C_DMAERR]      = w[`ATIE_EN_DMAERR];
    c[`ATIE_C_CKFAIL]      = w[`ATIE_EN_CKFAIL];
    c[`ATIE_C_SYNCERR]     = w[`ATIE_EN_SYNCERR];
    c[`ATIE_C_UNDRN]       = w[`ATIE_EN_UNDRN];
    return c;
  endfunction

  // Condition vector to status layout, with the error summary on top
  function automatic logic [8:0] pack_status(input atie_pkg::atie_cond_t c);
    logic [8:0] w;
    w                      = 9'h000;
    w[`ATIE_ST_DMAERR]     = c[`ATIE_C_DMAERR];
    w[`ATIE_ST_STAFRM]     = c[`ATIE_C_STAFRM];
    w[`ATIE_ST_DATA]       = c[`ATIE_C_DATA];
    w[`ATIE_ST_LAST]       = c[`ATIE_C_LAST];
    w[`ATIE_ST_CKFAIL]     = c[`ATIE_C_CKFAIL];
    w[`ATIE_ST_SYNCERR]    = c[`ATIE_C_SYNCERR];
    w[`ATIE_ST_UNDRN]      = c[`ATIE_C_UNDRN];
    w[`ATIE_ST_ERR]        = c[`ATIE_C_UNDRN] | c[`ATIE_C_SYNCERR] |
                             c[`ATIE_C_CKFAIL] | c[`ATIE_C_DMAERR];
    return w;
  endfunction

  // Status layout to condition vector, for write-one-to-clear
  function automatic atie_pkg::atie_cond_t unpack_status(input logic [7:0] w);
    atie_pkg::atie_cond_t c;
    c                      = `ATIE_FLAGS_RESET;
    c[`ATIE_C_DMAERR]      = w[`ATIE_ST_DMAERR];
    c[`ATIE_C_STAFRM]      = w[`ATIE_ST_STAFRM];
    c[`ATIE_C_DATA]        = w[`ATIE_ST_DATA];
    c[`ATIE_C_LAST]        = w[`ATIE_ST_LAST];
    c[`ATIE_C_CKFAIL]      = w[`ATIE_ST_CKFAIL];
    c[`ATIE_C_SYNCERR]     = w[`ATIE_ST_SYNCERR];
    c[`ATIE_C_UNDRN]       = w[`ATIE_ST_UNDRN];
    return c;
  endfunction

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------

  atie_pkg::atie_apb_state_e state_r;
  atie_pkg::atie_apb_state_e state_nxt;
  atie_pkg::atie_cond_t      enable_r;
  atie_pkg::atie_cond_t      enable_nxt;
  logic [31:0]               prdata_r;
  logic [31:0]               prdata_nxt;
  logic                      pready_r;
  logic                      pslverr_r;
  logic                      pslverr_nxt;
  logic                      irq_r;
  logic                      irq_nxt;

  // ------------------------------------------------------------------
  // Condition events and sticky flags
  // ------------------------------------------------------------------

  // A net, so each condition bit may have its own continuous assignment
  wire atie_pkg::atie_cond_t set_pulse;
  atie_pkg::atie_cond_t clr_mask;
  atie_pkg::atie_cond_t flags;
  atie_pkg::atie_cond_t pending;

  assign set_pulse[`ATIE_C_STAFRM]  = frame_start_seen;
  // A last-slot event always comes with data ready
  assign set_pulse[`ATIE_C_DATA]    = tx_buffer_empty | final_slot_seen;
  assign set_pulse[`ATIE_C_LAST]    = final_slot_seen;
  assign set_pulse[`ATIE_C_DMAERR]  = excess_write_error;
  assign set_pulse[`ATIE_C_CKFAIL]  = bit_clock_failure;
  assign set_pulse[`ATIE_C_SYNCERR] = unexpected_frame_sync;
  assign set_pulse[`ATIE_C_UNDRN]   = tx_underrun;

  atie_flag_bank u_flags (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .set_pulse (set_pulse),
    .clr_mask  (clr_mask),
    .flags     (flags)
  );

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------

  // Access phase seen while idle: answer on the following cycle
  wire access_start = psel & penable & (state_r == atie_pkg::ATIE_APB_IDLE);
  // Edge at which the master samples pready high: the write commits here
  wire access_done  = psel & penable & pready_r;

  wire hit_enable   = (paddr == `ATIE_OFS_ENABLE);
  wire hit_status   = (paddr == `ATIE_OFS_STATUS);
  wire hit_pending  = (paddr == `ATIE_OFS_PENDING);
  wire hit_any      = hit_enable | hit_status | hit_pending;

  // All writable fields sit in byte lane 0
  wire wr_lane0     = access_done & pwrite & pstrb[0];
  wire wr_enable    = wr_lane0 & hit_enable;
  wire wr_status    = wr_lane0 & hit_status;

  // Reserved enable bits never reach the register
  assign enable_nxt = wr_enable ? unpack_enable(pwdata[7:0]) : enable_r;

  // Writing zero leaves a flag alone; only ones clear
  assign clr_mask   = wr_status ? unpack_status(pwdata[7:0]) : `ATIE_FLAGS_RESET;

  // ------------------------------------------------------------------
  // Interrupt
  // ------------------------------------------------------------------

  // Each condition gated by its own enable bit
  assign pending = flags & enable_r;

  // Level output; one cycle behind the flags since it leaves from a flop
  assign irq_nxt = |pending;

  // ------------------------------------------------------------------
  // Read data and answer
  // ------------------------------------------------------------------

  wire [31:0] rd_enable  = {24'h00_0000, pack_enable(enable_r)};
  wire [31:0] rd_status  = {23'h00_0000, pack_status(flags)};
  wire [31:0] rd_pending = {23'h00_0000, pack_status(pending)};

  wire [31:0] rd_word = hit_enable  ? rd_enable  :
                        hit_status  ? rd_status  :
                        hit_pending ? rd_pending :
                        `ATIE_ZERO_WORD;

  assign state_nxt   = access_start ? atie_pkg::ATIE_APB_ANSWER : atie_pkg::ATIE_APB_IDLE;
  assign prdata_nxt  = (access_start & ~pwrite) ? rd_word : `ATIE_ZERO_WORD;
  // Unmapped addresses and writes to the read-only pending view report an error
  assign pslverr_nxt = access_start & (~hit_any | (pwrite & hit_pending));

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= atie_pkg::ATIE_APB_IDLE;
    end else begin
      case (state_nxt)
        atie_pkg::ATIE_APB_IDLE:   state_r <= atie_pkg::ATIE_APB_IDLE;
        atie_pkg::ATIE_APB_ANSWER: state_r <= atie_pkg::ATIE_APB_ANSWER;
        default:                   state_r <= atie_pkg::ATIE_APB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= `ATIE_ZERO_WORD;
    end else begin
      pready_r  <= access_start;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enable_r <= `ATIE_FLAGS_RESET;
      irq_r    <= 1'b0;
    end else begin
      enable_r <= enable_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign transmit_irq = irq_r;

endmodule // atie_top

`default_nettype wire

/* File: hdl/atie_consts.svh */
// Register offsets, field positions and reset values of the transmit interrupt enable block
`ifndef ATIE_CONSTS_SVH
`define ATIE_CONSTS_SVH

`define ATIE_ADDR_W        12
`define ATIE_OFS_ENABLE    12'h000
`define ATIE_OFS_STATUS    12'h004
`define ATIE_OFS_PENDING   12'h008

`define ATIE_NUM_COND      7
`define ATIE_ENABLE_RESET  8'h00
`define ATIE_FLAGS_RESET   7'h00
`define ATIE_ZERO_WORD     32'h0000_0000

// Enable register field positions
`define ATIE_EN_STAFRM     7
`define ATIE_EN_DATA       5
`define ATIE_EN_LAST       4
`define ATIE_EN_DMAERR     3
`define ATIE_EN_CKFAIL     2
`define ATIE_EN_SYNCERR    1
`define ATIE_EN_UNDRN      0

// Status register field positions
`define ATIE_ST_ERR        8
`define ATIE_ST_DMAERR     7
`define ATIE_ST_STAFRM     6
`define ATIE_ST_DATA       5
`define ATIE_ST_LAST       4
`define ATIE_ST_CKFAIL     2
`define ATIE_ST_SYNCERR    1
`define ATIE_ST_UNDRN      0

// Internal condition vector positions
`define ATIE_C_UNDRN       0
`define ATIE_C_SYNCERR     1
`define ATIE_C_CKFAIL      2
`define ATIE_C_DMAERR      3
`define ATIE_C_LAST        4
`define ATIE_C_DATA        5
`define ATIE_C_STAFRM      6

`endif

/* File: hdl/atie_pkg.sv */
// Types shared by the transmit interrupt enable block
package atie_pkg;

  typedef logic [6:0] atie_cond_t;

  typedef enum logic [1:0] {
    ATIE_APB_IDLE   = 2'b00,
    ATIE_APB_ANSWER = 2'b01
  } atie_apb_state_e;

endpackage

/* File: hdl/atie_flag_bank.sv */
// Sticky transmitter condition flags, set by hardware, cleared by software
`timescale 1ns/10ps
`default_nettype none
`include "atie_consts.svh"

module atie_flag_bank (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire atie_pkg::atie_cond_t set_pulse,
  input  wire atie_pkg::atie_cond_t clr_mask,
  output var  atie_pkg::atie_cond_t flags
);

  atie_pkg::atie_cond_t flags_r;
  atie_pkg::atie_cond_t flags_nxt;

  // A set in the same cycle as its clear wins, so no event is lost
  assign flags_nxt = (flags_r & ~clr_mask) | set_pulse;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_r <= `ATIE_FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

endmodule // atie_flag_bank

`default_nettype wire

/* File: tb/atie_properties.sv */
// Port-level properties of the transmit interrupt enable block
`timescale 1ns/10ps
`default_nettype none
`include "atie_consts.svh"
module atie_properties (
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [`ATIE_ADDR_W-1:0] paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [3:0]              pstrb,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    frame_start_seen,
  input wire logic                    tx_buffer_empty,
  input wire logic                    final_slot_seen,
  input wire logic                    excess_write_error,
  input wire logic                    bit_clock_failure,
  input wire logic                    unexpected_frame_sync,
  input wire logic                    tx_underrun,
  input wire logic                    transmit_irq
);
  logic [7:0] en_r;
  wire        wr_en = psel && penable && pready && pwrite && pstrb[0]
                      && paddr == `ATIE_OFS_ENABLE;
  wire  [7:0] ev = {frame_start_seen, 1'b0, tx_buffer_empty, final_slot_seen,
                    excess_write_error, bit_clock_failure, unexpected_frame_sync, tx_underrun};
  // Shadow of the enable register, rebuilt from committed APB writes
  always_ff @(posedge clk_sys) begin
    if (rst) en_r <= 8'h00;
    else if (wr_en) en_r <= pwdata[7:0] & 8'hBF;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside answer");
  a_unmapped_err: assert property (
    psel && penable && !pready && paddr > `ATIE_OFS_PENDING |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_reserved_zero: assert property (
    pready && !pwrite && paddr == `ATIE_OFS_ENABLE |-> prdata[31:8] == 24'h0 && !prdata[6])
    else $error("reserved enable bits not zero");
  a_enable_readback: assert property (
    pready && !pwrite && paddr == `ATIE_OFS_ENABLE |-> prdata[7:0] == en_r)
    else $error("enable readback differs");
  a_gate_off: assert property (transmit_irq |-> $past(en_r) != 8'h00)
    else $error("interrupt with all enables off");
  a_event_irq: assert property ((|(ev & en_r)) && !wr_en |-> ##2 transmit_irq)
    else $error("enabled event gave no interrupt");
endmodule // atie_properties
bind atie_top atie_properties u_props (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_start_seen(frame_start_seen),
  .tx_buffer_empty(tx_buffer_empty), .final_slot_seen(final_slot_seen),
  .excess_write_error(excess_write_error), .bit_clock_failure(bit_clock_failure),
  .unexpected_frame_sync(unexpected_frame_sync), .tx_underrun(tx_underrun),
  .transmit_irq(transmit_irq));
`default_nettype wire

/* File: tb/atie_irq_sink.sv */
// Interrupt controller stand-in that counts transmit interrupt requests
`timescale 1ns/10ps
`default_nettype none
module atie_irq_sink (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       transmit_irq,
  output var  logic [7:0] req_cnt
);
  logic seen_r;
  // Level input: one request per rising level, however long it stands
  always_ff @(posedge clk_sys) begin
    seen_r <= rst ? 1'b0 : transmit_irq;
    if (rst) req_cnt <= 8'h00;
    else if (transmit_irq && !seen_r) req_cnt <= req_cnt + 8'h01;
  end
endmodule // atie_irq_sink
`default_nettype wire

/* File: tb/tb_atie_top.sv */
// Self-checking bench for the transmit interrupt enable block
`timescale 1ns/10ps
`default_nettype none
`include "atie_consts.svh"
module tb_atie_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [7:0]  ev = 8'h00;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, transmit_irq, err;
  logic [7:0]  req_cnt, en, eff;
  int          error_cnt = 0;
  int          check_count = 0;
  // Event rows in enable-register layout, and the status each should leave
  logic [7:0]  row_ev [7] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
  logic [8:0]  row_st [7] = '{9'h040, 9'h020, 9'h030, 9'h180, 9'h104, 9'h102, 9'h101};
  always #12.5 clk_sys = ~clk_sys;
  atie_top dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_start_seen(ev[7]), .tx_buffer_empty(ev[5]),
    .final_slot_seen(ev[4]), .excess_write_error(ev[3]), .bit_clock_failure(ev[2]),
    .unexpected_frame_sync(ev[1]), .tx_underrun(ev[0]), .transmit_irq(transmit_irq));
  atie_irq_sink u_sink (.clk_sys(clk_sys), .rst(rst), .transmit_irq(transmit_irq),
    .req_cnt(req_cnt));
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Event lines in hold stay high for the whole transfer, commit edge included
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [7:0] hold);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    ev <= hold;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ev <= 8'h00;
    @(posedge clk_sys);
    if (n >= 20) begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF, 8'h00);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 4'hF, 8'h00);
    check(nm, rd, x);
  endtask
  task automatic pulse(input logic [7:0] v);
    ev <= v;
    @(posedge clk_sys);
    ev <= 8'h00;
    repeat (2) @(posedge clk_sys);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdc("enable_reset", `ATIE_OFS_ENABLE, 32'h0);
    for (int i = 0; i < 14; i++) begin
      eff = row_ev[i % 7] | (row_ev[i % 7][4] ? 8'h20 : 8'h00);
      en = (i < 7) ? row_ev[i % 7] : (8'hBF & ~eff);
      wr(`ATIE_OFS_ENABLE, {24'h0, en});
      pulse(row_ev[i % 7]);
      check("irq_row", {31'h0, transmit_irq}, {31'h0, i < 7});
      rdc("status_row", `ATIE_OFS_STATUS, {23'h0, row_st[i % 7]});
      wr(`ATIE_OFS_STATUS, 32'h1FF);
      @(posedge clk_sys);
      check("irq_cleared", {31'h0, transmit_irq}, 32'h0);
    end
    check("irq_requests", {24'h0, req_cnt}, 32'h7);
    wr(`ATIE_OFS_ENABLE, 32'hFFFF_FFFF);
    rdc("enable_reserved", `ATIE_OFS_ENABLE, 32'hBF);
    apb(1'b1, `ATIE_OFS_ENABLE, 32'h0, 4'h0, 8'h00);
    rdc("enable_nostrobe", `ATIE_OFS_ENABLE, 32'hBF);
    wr(`ATIE_OFS_ENABLE, 32'h1);
    pulse(8'h03);
    rdc("pending", `ATIE_OFS_PENDING, 32'h101);
    rdc("status_two", `ATIE_OFS_STATUS, 32'h103);
    apb(1'b1, `ATIE_OFS_STATUS, 32'h1FF, 4'hF, 8'h01);
    rdc("status_setwins", `ATIE_OFS_STATUS, 32'h101);
    check("irq_setwins", {31'h0, transmit_irq}, 32'h1);
    rdc("unmapped", 12'h00C, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    wr(`ATIE_OFS_PENDING, 32'hFFFF_FFFF);
    check("pending_wr_err", {31'h0, err}, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check("irq_reset", {31'h0, transmit_irq}, 32'h0);
    rdc("enable_rerst", `ATIE_OFS_ENABLE, 32'h0);
    rdc("status_rerst", `ATIE_OFS_STATUS, 32'h0);
    close_out();
  end
endmodule // tb_atie_top
`default_nettype wire
